// ---- rtl/pmc_pkg.sv ----
package pmc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int              ADDR_W              = 18;
  localparam logic [15:0]     IDX_POWER_CONTROL   = 16'h0087;
  localparam logic [15:0]     IDX_SLEEP_INTEGRITY = 16'h6262;
  localparam logic [15:0]     IDX_SLEEP_COMMAND   = 16'h0088;
  localparam logic [15:0]     IDX_CLOCK_CONTROL   = 16'h0089;
  localparam logic [15:0]     IDX_STATUS          = 16'h008a;
  localparam logic [ADDR_W-1:0] ADDR_POWER_CONTROL   = {IDX_POWER_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SLEEP_INTEGRITY = {IDX_SLEEP_INTEGRITY, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_SLEEP_COMMAND   = {IDX_SLEEP_COMMAND, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_CONTROL   = {IDX_CLOCK_CONTROL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_STATUS          = {IDX_STATUS, 2'b00};

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int          POS_IDLE      = 0;
  localparam int          POS_MODE      = 0;
  localparam int          POS_RSVD_ONE  = 2;
  localparam int          POS_CALDIS    = 7;
  localparam int          POS_CRC_EN    = 0;
  localparam int          POS_CRC_RES   = 2;
  localparam int          POS_FORCE     = 5;
  localparam int          POS_OSC       = 0;
  localparam int          POS_ST_STATE  = 0;
  localparam int          POS_ST_MODE   = 4;
  localparam int          POS_ST_CLK    = 8;
  localparam logic [1:0]  RST_MODE      = 2'h0;
  localparam logic        RST_CALDIS    = 1'b0;
  localparam logic        RST_OSC       = 1'b1;
  localparam logic        RST_FORCE     = 1'b0;
  localparam logic [1:0]  RST_CRC_RES   = 2'h0;
  localparam logic        RST_CRC_EN    = 1'b0;

  // ----------------------------------------------------------------
  // Encodings and timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_ACTIVE   = 2'h0;
  localparam logic [1:0]  MODE_LIGHT    = 2'h1;
  localparam logic [1:0]  MODE_DEEP     = 2'h2;
  localparam logic [1:0]  MODE_DEEPEST  = 2'h3;
  localparam logic [1:0]  CRC_PASS      = 2'h0;
  localparam logic [7:0]  CRC_POLY      = 8'h07;
  localparam logic [7:0]  CRC_INIT      = 8'hff;
  localparam logic [7:0]  PD_LIGHT_CYC  = 8'h04;
  localparam logic [7:0]  PU_LIGHT_CYC  = 8'h08;
  localparam logic [7:0]  PD_DEEP_CYC   = 8'h20;
  localparam logic [7:0]  PU_DEEP_CYC   = 8'h80;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_ACTIVE, ST_IDLE, ST_PWR_DOWN, ST_SLEEP, ST_PWR_UP, ST_RET_CHECK
  } pmc_state_t;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata;
  } pmc_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pmc_apb_rsp_t;

  typedef struct packed {
    logic regulator_on;
    logic hf_rc_on;
    logic hf_xtal_on;
    logic lf_osc_on;
    logic cpu_clk_en;
    logic sleep_timer_en;
    logic ext_wake_en;
    logic io_hold;
    logic bod_en;
    logic por_en;
    logic partial_retain;
    logic clk_sel_xtal;
  } pmc_power_t;

  localparam pmc_power_t PWR_RESET = '{regulator_on: 1'b1, hf_rc_on: 1'b1, hf_xtal_on: 1'b0,
    lf_osc_on: 1'b1, cpu_clk_en: 1'b1, sleep_timer_en: 1'b1, ext_wake_en: 1'b1,
    io_hold: 1'b0, bod_en: 1'b1, por_en: 1'b1, partial_retain: 1'b0, clk_sel_xtal: 1'b0};

endpackage

// ---- rtl/pmc_crc8.sv ----
`timescale 1ns/10ps
module pmc_crc8 #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] data,
  output logic      [7:0]   crc
);

  // Bitwise serial form, unrolled by synthesis; MSB first
  always_comb begin
    crc = pmc_pkg::CRC_INIT;
    for (int i = W - 1; i >= 0; i--) begin
      crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ data[i]) ? pmc_pkg::CRC_POLY : 8'h00);
    end
  end

endmodule // pmc_crc8

// ---- rtl/pmc_power_mode_ctrl.sv ----
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module pmc_power_mode_ctrl #(
  parameter logic [7:0] PD_LIGHT = pmc_pkg::PD_LIGHT_CYC,
  parameter logic [7:0] PU_LIGHT = pmc_pkg::PU_LIGHT_CYC,
  parameter logic [7:0] PD_DEEP  = pmc_pkg::PD_DEEP_CYC,
  parameter logic [7:0] PU_DEEP  = pmc_pkg::PU_DEEP_CYC,
  parameter int         RET_W    = 16
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire pmc_pkg::pmc_apb_req_t apb_req,
  output pmc_pkg::pmc_apb_rsp_t      apb_rsp,
  input  wire logic                  irq_any,
  input  wire logic                  ext_irq,
  input  wire logic                  sleep_timer_expired,
  input  wire logic [RET_W-1:0]      retained_cfg,
  output pmc_pkg::pmc_power_t        power,
  output logic                       watchdog_reset
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pmc_pkg::pmc_state_t   st;
    logic [1:0]            mode;
    logic                  osc_cap;
    logic [7:0]            cnt;
    logic [1:0]            sleep_mode;
    logic                  caldis;
    logic                  osc_sel;
    logic                  force_rst;
    logic [1:0]            crc_res;
    logic                  crc_en;
    logic [7:0]            crc_lo_ref;
    logic [7:0]            crc_hi_ref;
    pmc_pkg::pmc_power_t   pwr;
    logic                  wdog;
    pmc_pkg::pmc_apb_rsp_t rsp;
  } pmc_ctrl_state_t;

  localparam pmc_ctrl_state_t STATE_RESET = '{
    st:         pmc_pkg::ST_ACTIVE,
    mode:       pmc_pkg::MODE_ACTIVE,
    osc_cap:    pmc_pkg::RST_OSC,
    cnt:        8'h00,
    sleep_mode: pmc_pkg::RST_MODE,
    caldis:     pmc_pkg::RST_CALDIS,
    osc_sel:    pmc_pkg::RST_OSC,
    force_rst:  pmc_pkg::RST_FORCE,
    crc_res:    pmc_pkg::RST_CRC_RES,
    crc_en:     pmc_pkg::RST_CRC_EN,
    crc_lo_ref: 8'h00,
    crc_hi_ref: 8'h00,
    pwr:        pmc_pkg::PWR_RESET,
    wdog:       1'b0,
    rsp:        '{prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0}
  };

  pmc_ctrl_state_t state_reg;
  pmc_ctrl_state_t state_next;

  logic       acc;
  logic       wr;
  logic       mapped;
  logic [31:0] rd_data;
  logic       idle_req;
  logic       wake;
  logic [1:0] crc_now;
  logic [7:0] crc_lo_now;
  logic [7:0] crc_hi_now;

  // ----------------------------------------------------------------
  // Retention signatures
  // ----------------------------------------------------------------
  pmc_crc8 #(.W(RET_W / 2)) u_crc_lo (
    .data (retained_cfg[RET_W/2-1:0]),
    .crc  (crc_lo_now)
  );

  pmc_crc8 #(.W(RET_W - RET_W / 2)) u_crc_hi (
    .data (retained_cfg[RET_W-1:RET_W/2]),
    .crc  (crc_hi_now)
  );

  // Low bit flags the low half, high bit the high half
  assign crc_now = {crc_hi_now != state_reg.crc_hi_ref,
                    crc_lo_now != state_reg.crc_lo_ref};

  // ----------------------------------------------------------------
  // Power controls per state
  // ----------------------------------------------------------------
  function automatic pmc_pkg::pmc_power_t power_for(
    input pmc_pkg::pmc_state_t st,
    input logic [1:0]          mode,
    input logic                osc_sel,
    input logic                osc_cap
  );
    pmc_pkg::pmc_power_t p;
    p = pmc_pkg::PWR_RESET;
    p.hf_xtal_on   = ~osc_sel;
    p.clk_sel_xtal = ~osc_sel;
    unique case (st)
      pmc_pkg::ST_ACTIVE, pmc_pkg::ST_RET_CHECK: begin
        p.cpu_clk_en = (st == pmc_pkg::ST_ACTIVE);
      end
      pmc_pkg::ST_IDLE: begin
        p.cpu_clk_en = 1'b0;
      end
      pmc_pkg::ST_PWR_DOWN: begin
        p.cpu_clk_en = 1'b0;
        p.io_hold    = (mode != pmc_pkg::MODE_LIGHT);
      end
      pmc_pkg::ST_SLEEP: begin
        p.cpu_clk_en   = 1'b0;
        p.hf_rc_on     = 1'b0;
        p.hf_xtal_on   = 1'b0;
        p.clk_sel_xtal = 1'b0;
        if (mode != pmc_pkg::MODE_LIGHT) begin
          p.regulator_on = 1'b0;
          p.io_hold      = 1'b1;
          p.bod_en       = 1'b0;
        end
        if (mode == pmc_pkg::MODE_DEEPEST) begin
          p.lf_osc_on      = 1'b0;
          p.sleep_timer_en = 1'b0;
          p.partial_retain = 1'b1;
        end
      end
      pmc_pkg::ST_PWR_UP: begin
        // Restart on the RC source, crystal warms up meanwhile when osc_cap is 0
        p.cpu_clk_en   = 1'b0;
        p.hf_xtal_on   = ~osc_cap;
        p.clk_sel_xtal = 1'b0;
        p.io_hold      = (mode != pmc_pkg::MODE_LIGHT);
      end
    endcase
    p.por_en = 1'b1;
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    acc        = apb_req.psel & apb_req.penable & state_reg.rsp.pready;
    wr         = acc & apb_req.pwrite;
    mapped     = 1'b1;
    rd_data    = 32'h0000_0000;
    idle_req   = 1'b0;
    wake       = 1'b0;

    unique case (apb_req.paddr)
      pmc_pkg::ADDR_POWER_CONTROL: begin
        rd_data = 32'h0000_0000;
      end
      pmc_pkg::ADDR_SLEEP_COMMAND: begin
        rd_data[pmc_pkg::POS_MODE +: 2]  = state_reg.sleep_mode;
        rd_data[pmc_pkg::POS_RSVD_ONE]   = 1'b1;
        rd_data[pmc_pkg::POS_CALDIS]     = state_reg.caldis;
      end
      pmc_pkg::ADDR_CLOCK_CONTROL: begin
        rd_data[pmc_pkg::POS_OSC] = state_reg.osc_sel;
      end
      pmc_pkg::ADDR_SLEEP_INTEGRITY: begin
        rd_data[pmc_pkg::POS_CRC_EN]       = state_reg.crc_en;
        rd_data[pmc_pkg::POS_CRC_RES +: 2] = state_reg.crc_res;
        rd_data[pmc_pkg::POS_FORCE]        = state_reg.force_rst;
      end
      pmc_pkg::ADDR_STATUS: begin
        rd_data[pmc_pkg::POS_ST_STATE +: 3] = state_reg.st;
        rd_data[pmc_pkg::POS_ST_MODE +: 2]  = state_reg.mode;
        rd_data[pmc_pkg::POS_ST_CLK]        = state_reg.pwr.clk_sel_xtal;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase

    // Bus answer: one wait state, pready straight from a flop
    state_next.rsp.pready  = apb_req.psel & apb_req.penable & ~state_reg.rsp.pready;
    state_next.rsp.pslverr = state_next.rsp.pready & ~mapped;
    state_next.rsp.prdata  = (state_next.rsp.pready & ~apb_req.pwrite) ? rd_data : 32'h0000_0000;

    // Register writes
    state_next.wdog = 1'b0;
    if (wr) begin
      unique case (apb_req.paddr)
        pmc_pkg::ADDR_POWER_CONTROL: begin
          idle_req = apb_req.pwdata[pmc_pkg::POS_IDLE];
        end
        pmc_pkg::ADDR_SLEEP_COMMAND: begin
          state_next.sleep_mode = apb_req.pwdata[pmc_pkg::POS_MODE +: 2];
          state_next.caldis     = apb_req.pwdata[pmc_pkg::POS_CALDIS];
        end
        pmc_pkg::ADDR_CLOCK_CONTROL: begin
          state_next.osc_sel = apb_req.pwdata[pmc_pkg::POS_OSC];
        end
        pmc_pkg::ADDR_SLEEP_INTEGRITY: begin
          state_next.crc_en    = apb_req.pwdata[pmc_pkg::POS_CRC_EN];
          state_next.force_rst = apb_req.pwdata[pmc_pkg::POS_FORCE];
          // Writing 0 clears a result bit, writing 1 leaves it
          state_next.crc_res   = state_reg.crc_res & apb_req.pwdata[pmc_pkg::POS_CRC_RES +: 2];
          state_next.wdog      = apb_req.pwdata[pmc_pkg::POS_FORCE];
        end
        default: begin
        end
      endcase
    end

    // Mode sequencing
    unique case (state_reg.st)
      pmc_pkg::ST_ACTIVE: begin
        if (idle_req) begin
          state_next.mode    = state_reg.sleep_mode;
          state_next.osc_cap = state_reg.osc_sel;
          if (state_reg.sleep_mode == pmc_pkg::MODE_ACTIVE) begin
            state_next.st = pmc_pkg::ST_IDLE;
          end else begin
            state_next.st  = pmc_pkg::ST_PWR_DOWN;
            // Deepest shares the deep sequence lengths
            state_next.cnt = (state_reg.sleep_mode == pmc_pkg::MODE_LIGHT) ?
                             PD_LIGHT - 8'h01 : PD_DEEP - 8'h01;
            if (state_reg.sleep_mode != pmc_pkg::MODE_LIGHT) begin
              state_next.crc_lo_ref = crc_lo_now;
              state_next.crc_hi_ref = crc_hi_now;
            end
          end
        end
      end
      pmc_pkg::ST_IDLE: begin
        if (irq_any) begin
          state_next.st = pmc_pkg::ST_ACTIVE;
        end
      end
      pmc_pkg::ST_PWR_DOWN: begin
        if (state_reg.cnt == 8'h00) begin
          state_next.st = pmc_pkg::ST_SLEEP;
        end else begin
          state_next.cnt = state_reg.cnt - 8'h01;
        end
      end
      pmc_pkg::ST_SLEEP: begin
        // Sleep timer is stopped in deepest sleep, so only pins wake it
        wake = ext_irq | (sleep_timer_expired &
               (state_reg.mode != pmc_pkg::MODE_DEEPEST));
        if (wake) begin
          state_next.st  = pmc_pkg::ST_PWR_UP;
          state_next.cnt = (state_reg.mode == pmc_pkg::MODE_LIGHT) ?
                           PU_LIGHT - 8'h01 : PU_DEEP - 8'h01;
        end
      end
      pmc_pkg::ST_PWR_UP: begin
        if (state_reg.cnt != 8'h00) begin
          state_next.cnt = state_reg.cnt - 8'h01;
        end else if (state_reg.mode == pmc_pkg::MODE_LIGHT) begin
          state_next.st = pmc_pkg::ST_ACTIVE;
        end else begin
          state_next.st = pmc_pkg::ST_RET_CHECK;
        end
      end
      pmc_pkg::ST_RET_CHECK: begin
        // Hardware result replaces the field and beats a same-cycle clear
        state_next.crc_res = crc_now;
        if (state_reg.crc_en && crc_now != pmc_pkg::CRC_PASS) begin
          state_next.wdog = 1'b1;
        end
        state_next.st = pmc_pkg::ST_ACTIVE;
      end
    endcase

    state_next.pwr = power_for(state_next.st, state_next.mode,
                               state_next.osc_sel, state_next.osc_cap);
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign apb_rsp        = state_reg.rsp;
  assign power          = state_reg.pwr;
  assign watchdog_reset = state_reg.wdog;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  active_power_a: assert property (
    state_reg.st == pmc_pkg::ST_ACTIVE |-> power.regulator_on && power.lf_osc_on &&
      (power.hf_rc_on || power.hf_xtal_on) && power.cpu_clk_en)
    else $error("active mode power missing");

  idle_entry_a: assert property (
    state_reg.st == pmc_pkg::ST_ACTIVE && wr && apb_req.paddr == pmc_pkg::ADDR_POWER_CONTROL &&
      apb_req.pwdata[pmc_pkg::POS_IDLE] && state_reg.sleep_mode == pmc_pkg::MODE_ACTIVE
      |=> state_reg.st == pmc_pkg::ST_IDLE && !power.cpu_clk_en && power.regulator_on)
    else $error("idle not entered");

  idle_wake_a: assert property (
    state_reg.st == pmc_pkg::ST_IDLE && irq_any |=> power.cpu_clk_en)
    else $error("interrupt did not end idle");

  idle_read_a: assert property (
    state_reg.rsp.pready && !apb_req.pwrite && apb_req.paddr == pmc_pkg::ADDR_POWER_CONTROL
      |-> state_reg.rsp.prdata == 32'h0000_0000)
    else $error("idle bit read back nonzero");

  light_sleep_a: assert property (
    state_reg.st == pmc_pkg::ST_SLEEP && state_reg.mode == pmc_pkg::MODE_LIGHT
      |-> !power.hf_rc_on && !power.hf_xtal_on && power.regulator_on && power.lf_osc_on)
    else $error("light sleep power wrong");

  deep_sleep_a: assert property (
    state_reg.st == pmc_pkg::ST_SLEEP && state_reg.mode == pmc_pkg::MODE_DEEP
      |-> !power.regulator_on && power.lf_osc_on && power.sleep_timer_en &&
          power.por_en && !power.bod_en && power.io_hold)
    else $error("deep sleep power wrong");

  deepest_sleep_a: assert property (
    state_reg.st == pmc_pkg::ST_SLEEP && state_reg.mode == pmc_pkg::MODE_DEEPEST
      |-> !power.regulator_on && !power.lf_osc_on && !power.hf_rc_on &&
          power.ext_wake_en && power.partial_retain && power.io_hold)
    else $error("deepest sleep power wrong");

  timer_wake_a: assert property (
    state_reg.st == pmc_pkg::ST_SLEEP && state_reg.mode != pmc_pkg::MODE_DEEPEST &&
      sleep_timer_expired |=> state_reg.st == pmc_pkg::ST_PWR_UP)
    else $error("sleep timer did not wake");

  deepest_hold_a: assert property (
    state_reg.st == pmc_pkg::ST_SLEEP && state_reg.mode == pmc_pkg::MODE_DEEPEST && !ext_irq
      |=> state_reg.st == pmc_pkg::ST_SLEEP)
    else $error("deepest sleep left without pin interrupt");

  light_pd_a: assert property (
    $rose(state_reg.st == pmc_pkg::ST_PWR_DOWN) && state_reg.mode == pmc_pkg::MODE_LIGHT
      |-> ##4 state_reg.st == pmc_pkg::ST_SLEEP)
    else $error("light power-down length wrong");

  wake_clock_a: assert property (
    $past(state_reg.st) == pmc_pkg::ST_PWR_UP && state_reg.st != pmc_pkg::ST_PWR_UP
      |-> power.clk_sel_xtal == !state_reg.osc_cap && $past(power.clk_sel_xtal) == 1'b0)
    else $error("wake clock selection wrong");

  crc_reset_a: assert property (
    state_reg.st == pmc_pkg::ST_RET_CHECK && state_reg.crc_en && crc_now != pmc_pkg::CRC_PASS
      |=> watchdog_reset && state_reg.crc_res == $past(crc_now) ##1 !watchdog_reset)
    else $error("retention failure did not reset");

  force_reset_a: assert property (
    wr && apb_req.paddr == pmc_pkg::ADDR_SLEEP_INTEGRITY && apb_req.pwdata[pmc_pkg::POS_FORCE]
      |=> watchdog_reset)
    else $error("software reboot ignored");

endmodule // pmc_power_mode_ctrl

// ---- tb/pmc_wake_model.sv ----
`timescale 1ns/10ps
// Wake sources: lines[0] any irq, [1] pin irq, [2] sleep timer.
// Held 16 cycles, since a level wake is only seen once asleep.
module pmc_wake_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] fire,
  input  wire logic [7:0] delay,
  output logic      [2:0] lines
);
  logic [2:0] armed;
  logic [8:0] cnt;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed <= 3'h0;
      cnt   <= 9'h000;
      lines <= 3'h0;
    end else if (fire != 3'h0) begin
      armed <= fire;
      cnt   <= {1'b0, delay} + 9'h010;
      lines <= 3'h0;
    end else if (cnt != 9'h000) begin
      cnt   <= cnt - 9'h001;
      lines <= (cnt <= 9'h010) ? armed : 3'h0;
    end else begin
      lines <= 3'h0;
    end
  end
endmodule // pmc_wake_model

// ---- tb/power_mode_controller_tb_top.sv ----
`timescale 1ns/10ps
module power_mode_controller_tb_top;
  logic                  clk;
  logic                  reset_n;
  pmc_pkg::pmc_apb_req_t apb_req;
  pmc_pkg::pmc_apb_rsp_t apb_rsp;
  pmc_pkg::pmc_power_t   power;
  logic                  watchdog_reset;
  logic [15:0]           retained_cfg;
  logic [2:0]            fire;
  logic [2:0]            lines;
  logic [7:0]            delay;
  logic [32:0]           exp_q[$];
  logic                  wd_q[$];
  int                    checks = 0;
  int                    miscompares = 0;

  // Default sequence lengths, so the light power-down check sees its real count
  pmc_power_mode_ctrl pmc_power_mode_ctrl_inst (
    .clk(clk), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .irq_any(lines[0]), .ext_irq(lines[1]), .sleep_timer_expired(lines[2]),
    .retained_cfg(retained_cfg), .power(power), .watchdog_reset(watchdog_reset));

  pmc_wake_model pmc_wake_model_inst (
    .clk(clk), .reset_n(reset_n), .fire(fire), .delay(delay), .lines(lines));

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic report(input logic ok, input logic [32:0] g, input logic [32:0] e);
    checks++;
    if (!ok) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_bus(input logic [32:0] g, input logic [32:0] e);
    report(g === e, g, e);
  endtask
  task automatic cmp_pow(input logic [11:0] g, input logic [11:0] e);
    report(g === e, 33'(g), 33'(e));
  endtask
  task automatic cmp_wd(input logic g, input logic e);
    report(g === e, 33'(g), 33'(e));
  endtask

  always @(posedge clk) begin
    if (apb_rsp.pready === 1'b1) begin
      cmp_bus({apb_rsp.pslverr, apb_rsp.prdata}, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
    end
    if (watchdog_reset === 1'b1) begin
      cmp_wd(1'b1, wd_q.size() > 0 ? wd_q.pop_front() : 1'b0);
    end
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    apb_req.penable <= 1'b1;
    // No local limit: a slave that never answers is caught by the watchdog
    do begin
      @(posedge clk);
    end while (apb_rsp.pready !== 1'b1);
    apb_req <= '0;
  endtask
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask
  task automatic wake(input logic [2:0] s, input logic [7:0] d);
    fire <= s;
    delay <= d;
    @(posedge clk);
    fire <= 3'h0;
  endtask
  // Bounded wait for masked power bits; a miss shows in the compare
  task automatic wait_pow(input logic [11:0] mk, input logic [11:0] v, input int lim,
                          output int n);
    n = 0;
    while ((power & mk) !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    cmp_pow(power & mk, v);
  endtask
  task automatic sleep(input logic [1:0] m, input logic [11:0] mk, input logic [11:0] v,
                       output int n);
    wr(pmc_pkg::ADDR_SLEEP_COMMAND, {29'h0, 1'b1, m});
    wr(pmc_pkg::ADDR_POWER_CONTROL, 32'h01);
    wait_pow(mk, v, 200, n);
  endtask
  task automatic done(input string s);
    repeat (24) @(posedge clk);
    $display("test %s finished", s);
  endtask
  task automatic wrap_up();
    miscompares += exp_q.size() + wd_q.size();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // The tests take about one thousand cycles
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end

  initial begin
    int n, pl, pd, px;
    logic [1:0]  k;
    logic [15:0] x;
    apb_req = '0;
    fire = 3'h0;
    delay = 8'h00;
    reset_n = 1'b0;
    void'($urandom(32'h088f));
    retained_cfg = 16'($urandom);
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    cmp_pow(power, pmc_pkg::PWR_RESET);
    rd(pmc_pkg::ADDR_SLEEP_COMMAND, 32'h04);
    rd(pmc_pkg::ADDR_CLOCK_CONTROL, 32'h01);
    rd(pmc_pkg::ADDR_SLEEP_INTEGRITY, 32'h00);
    rd(pmc_pkg::ADDR_POWER_CONTROL, 32'h00);
    wr(pmc_pkg::ADDR_SLEEP_COMMAND, 32'h84);
    rd(pmc_pkg::ADDR_SLEEP_COMMAND, 32'h84);
    apb(1'b0, 18'h3fff0, 32'h0, {1'b1, 32'h0});
    done("registers");
    sleep(pmc_pkg::MODE_ACTIVE, 12'hd80, 12'hd00, n);
    rd(pmc_pkg::ADDR_POWER_CONTROL, 32'h00);
    rd(pmc_pkg::ADDR_STATUS, 32'h01);
    wake(3'b001, 8'h03);
    wait_pow(12'hd91, 12'hd80, 40, n);
    done("idle");
    sleep(pmc_pkg::MODE_LIGHT, 12'hf80, 12'h900, pl);
    wake(3'b100, 8'h02);
    wait_pow(12'hd91, 12'hd80, 100, n);
    done("light");
    wr(pmc_pkg::ADDR_SLEEP_INTEGRITY, 32'h01);
    wr(pmc_pkg::ADDR_CLOCK_CONTROL, 32'h00);
    sleep(pmc_pkg::MODE_DEEP, 12'hffc, 12'h174, pd);
    wake(3'b100, 8'h40);
    wait_pow(12'h991, 12'h981, 300, n);
    rd(pmc_pkg::ADDR_STATUS, 32'h120);
    rd(pmc_pkg::ADDR_SLEEP_INTEGRITY, 32'h01);
    cmp_bus(33'(pl < pd), 33'h1);
    done("deep");
    wr(pmc_pkg::ADDR_CLOCK_CONTROL, 32'h01);
    sleep(pmc_pkg::MODE_DEEPEST, 12'hfbe, 12'h036, px);
    wake(3'b100, 8'h02);
    repeat (40) @(posedge clk);
    wait_pow(12'hfbe, 12'h036, 1, n);
    wake(3'b010, 8'h10);
    wait_pow(12'hd91, 12'hd80, 300, n);
    cmp_bus(33'(px), 33'(pd));
    done("deepest");
    k = 2'($urandom_range(3, 1));
    x = 16'($urandom) | 16'h0101;
    sleep(pmc_pkg::MODE_DEEP, 12'hffc, 12'h174, n);
    retained_cfg <= retained_cfg ^ (x & {{8{k[1]}}, {8{k[0]}}});
    wd_q.push_back(1'b1);
    wake(3'b010, 8'h08);
    wait_pow(12'h991, 12'h980, 300, n);
    rd(pmc_pkg::ADDR_SLEEP_INTEGRITY, {28'h0, k, 2'b01});
    done("retention");
    wd_q.push_back(1'b1);
    wr(pmc_pkg::ADDR_SLEEP_INTEGRITY, 32'h20);
    done("reboot");
    wrap_up();
  end
endmodule // power_mode_controller_tb_top
